// File: inc/ldr_pkg.sv
package ldr_pkg;

  localparam int DW       = 8;
  localparam int STR_NUM  = 4;

  // Register offsets
  localparam logic [7:0] OFF_STR  = 8'h00;
  localparam logic [7:0] OFF_CFG  = 8'h02;
  localparam logic [7:0] OFF_FLT  = 8'h08;
  localparam logic [7:0] OFF_PEAK = 8'h0e;
  localparam logic [7:0] OFF_RSV  = 8'h10;
  localparam logic [7:0] OFF_OPT  = 8'h11;
  localparam logic [7:0] OFF_DAC1 = 8'h14;
  localparam logic [7:0] OFF_DAC2 = 8'h15;
  localparam logic [7:0] OFF_OST  = 8'h18;

  // Default values held in the nonvolatile store, and the read value of unmapped offsets
  localparam logic [7:0] RST_STR  = 8'h0f;
  localparam logic [7:0] RST_CFG  = 8'h4e;
  localparam logic [7:0] RST_FLT  = 8'h0f;
  localparam logic [7:0] RST_PEAK = 8'h7f;
  localparam logic [7:0] RST_RSV  = 8'h04;
  localparam logic [7:0] RST_OPT  = 8'h1a;
  localparam logic [7:0] RD_NONE  = 8'h00;

  // Configuration register fields
  localparam int CFG_SLEEP    = 0;
  localparam int CFG_OPT_OUT  = 1;
  localparam int CFG_OPEN     = 2;
  localparam int CFG_SHORT    = 3;
  localparam int CFG_TIMEOUT  = 6;
  localparam int CFG_FOLDBACK = 7;

  // Optimizer state register fields
  localparam int OST_OUT_LO = 3;
  localparam int OST_IGN    = 5;

  // Nonvolatile store layout
  localparam int         NVM_DEPTH = 6;
  localparam int         NVM_IW    = 3;
  localparam logic [2:0] NVM_LAST  = 3'h5;

  // Serial bus framing; address value is arbitrary
  localparam logic [6:0] DEV_ADDR  = 7'h2a;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int         MSB       = 7;

  typedef enum logic [2:0] {
    B_IDLE, B_ADDR, B_ADDR_ACK, B_RX, B_RX_ACK, B_TX, B_TX_ACK
  } ldr_bus_st_t;

  typedef enum logic [1:0] {
    L_FETCH, L_STORE, L_DONE
  } ldr_ld_st_t;

endpackage : ldr_pkg

// File: hw/ldr_sync.sv
`timescale 1ns/10ps
module ldr_sync #(
  parameter int W = 1
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : ldr_sync

// File: hw/ldr_nvm.sv
`timescale 1ns/10ps
module ldr_nvm (
  // Clock and control
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  // Read port
  input  wire logic [ldr_pkg::NVM_IW-1:0] idx,
  output logic      [7:0]                addr_r,
  output logic      [7:0]                data_r
);

  localparam logic [7:0] ADDR_TAB [ldr_pkg::NVM_DEPTH] = '{
    ldr_pkg::OFF_STR, ldr_pkg::OFF_CFG, ldr_pkg::OFF_FLT,
    ldr_pkg::OFF_PEAK, ldr_pkg::OFF_RSV, ldr_pkg::OFF_OPT
  };
  localparam logic [7:0] DATA_TAB [ldr_pkg::NVM_DEPTH] = '{
    ldr_pkg::RST_STR, ldr_pkg::RST_CFG, ldr_pkg::RST_FLT,
    ldr_pkg::RST_PEAK, ldr_pkg::RST_RSV, ldr_pkg::RST_OPT
  };

  wire logic       in_range = (idx <= ldr_pkg::NVM_LAST);
  wire logic [7:0] addr_sel = in_range ? ADDR_TAB[idx] : ldr_pkg::OFF_STR;
  wire logic [7:0] data_sel = in_range ? DATA_TAB[idx] : ldr_pkg::RST_STR;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_r <= ldr_pkg::OFF_STR;
      data_r <= ldr_pkg::RST_STR;
    end else if (ce) begin
      addr_r <= addr_sel;
      data_r <= data_sel;
    end
  end

endmodule : ldr_nvm

// File: hw/ldr_regbank.sv
`timescale 1ns/10ps
// Behaviour
// - Power-up loads defaults from nonvolatile store
// - String switches default to 0f
// - Configuration defaults to 4e
// - Fault watch select defaults to 0f
// - Peak current level defaults to 7f
// - Optimizer control defaults to 1a
// - Chip enable high restores every default
module ldr_regbank (
  // Clock, reset, clock enable
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       CE,
  // Chip enable pin
  input  wire logic       EN_PIN,
  // Two-wire serial bus
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  // Readback from optimizer logic
  input  wire logic [7:0] OPTIMIZER_DAC_ONE_READBACK,
  input  wire logic [7:0] OPTIMIZER_DAC_TWO_READBACK,
  input  wire logic       FEEDBACK_IN_IGNORE_FLAG,
  input  wire logic [1:0] OPTIMIZER_OUTCOME_BITS,
  // Control outputs
  output logic [3:0]      STRING_OUTPUT_SWITCHES,
  output logic            SLEEP_ON,
  output logic            OPTIMIZER_OUTPUT_ON,
  output logic            OPEN_DETECT_ON,
  output logic            SHORT_DETECT_ON,
  output logic            BUS_TIMEOUT_ON,
  output logic            CURRENT_FOLDBACK_ON,
  output logic [3:0]      FAULT_WATCH_SELECT,
  output logic [7:0]      PEAK_CURRENT_LEVEL,
  output logic [7:0]      OPTIMIZER_CONTROL,
  output logic            LOAD_DONE
);

  // Pin synchronisers
  logic scl_s;
  logic sda_s;
  logic en_s;
  logic scl_d;
  logic sda_d;

  ldr_sync #(.W(3)) u_sync (
    .clk   (CLK),
    .rst_b (RST_B),
    .ce    (CE),
    .d     ({SCL_IN, SDA_IN, EN_PIN}),
    .q     ({scl_s, sda_s, en_s})
  );

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      scl_d <= 1'b0;
      sda_d <= 1'b0;
    end else if (CE) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire logic scl_rise = scl_s & ~scl_d;
  wire logic scl_fall = ~scl_s & scl_d;
  wire logic bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire logic bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // Default loader walking the nonvolatile store
  ldr_pkg::ldr_ld_st_t         ld_st_r;
  logic [ldr_pkg::NVM_IW-1:0]  ld_idx_r;
  logic                        load_done_r;
  logic [7:0]                  nvm_addr;
  logic [7:0]                  nvm_data;

  ldr_nvm u_nvm (
    .clk    (CLK),
    .rst_b  (RST_B),
    .ce     (CE),
    .idx    (ld_idx_r),
    .addr_r (nvm_addr),
    .data_r (nvm_data)
  );

  wire logic ld_last = (ld_idx_r == ldr_pkg::NVM_LAST);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ld_st_r     <= ldr_pkg::L_FETCH;
      ld_idx_r    <= '0;
      load_done_r <= 1'b0;
    end else if (CE) begin
      case (ld_st_r)
        ldr_pkg::L_FETCH: begin
          ld_st_r <= ldr_pkg::L_STORE;
        end
        ldr_pkg::L_STORE: begin
          ld_st_r     <= (ld_last && !en_s) ? ldr_pkg::L_DONE
                                            : ldr_pkg::L_FETCH;
          ld_idx_r    <= ld_last ? '0 : ld_idx_r + 3'h1;
          load_done_r <= ld_last && !en_s;
        end
        ldr_pkg::L_DONE: begin
          if (en_s) begin
            ld_st_r     <= ldr_pkg::L_FETCH;
            ld_idx_r    <= '0;
            load_done_r <= 1'b0;
          end
        end
        default: begin
          ld_st_r <= ldr_pkg::L_FETCH;
        end
      endcase
    end
  end

  // Serial bus slave
  ldr_pkg::ldr_bus_st_t bus_st_r, bus_st_nxt;
  logic [3:0]           cnt_r, cnt_nxt;
  logic [7:0]           rx_r, rx_nxt;
  logic [7:0]           tx_r, tx_nxt;
  logic [7:0]           ptr_r, ptr_nxt;
  logic                 ptr_seen_r, ptr_seen_nxt;
  logic                 rw_r, rw_nxt;
  logic                 nack_r, nack_nxt;
  logic                 drv_r, drv_nxt;
  logic                 bus_wr;
  logic [7:0]           rd_data;

  wire logic byte_in = (cnt_r == ldr_pkg::BYTE_BITS);

  always_comb begin
    bus_st_nxt   = bus_st_r;
    cnt_nxt      = cnt_r;
    rx_nxt       = rx_r;
    tx_nxt       = tx_r;
    ptr_nxt      = ptr_r;
    ptr_seen_nxt = ptr_seen_r;
    rw_nxt       = rw_r;
    nack_nxt     = nack_r;
    drv_nxt      = drv_r;
    bus_wr       = 1'b0;
    if (bus_start) begin
      bus_st_nxt = ldr_pkg::B_ADDR;
      cnt_nxt    = '0;
      drv_nxt    = 1'b0;
    end else if (bus_stop) begin
      bus_st_nxt = ldr_pkg::B_IDLE;
      drv_nxt    = 1'b0;
    end else begin
      case (bus_st_r)
        ldr_pkg::B_IDLE: begin
          drv_nxt = 1'b0;
        end
        ldr_pkg::B_ADDR, ldr_pkg::B_RX: begin
          if (scl_rise) begin
            rx_nxt  = {rx_r[ldr_pkg::MSB-1:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && byte_in) begin
            if (bus_st_r == ldr_pkg::B_ADDR) begin
              if (rx_r[ldr_pkg::MSB:1] == ldr_pkg::DEV_ADDR) begin
                rw_nxt       = rx_r[0];
                ptr_seen_nxt = 1'b0;
                drv_nxt      = 1'b1;
                bus_st_nxt   = ldr_pkg::B_ADDR_ACK;
              end else begin
                bus_st_nxt = ldr_pkg::B_IDLE;
              end
            end else begin
              if (!ptr_seen_r) begin
                ptr_nxt      = rx_r;
                ptr_seen_nxt = 1'b1;
              end else begin
                bus_wr  = 1'b1;
                ptr_nxt = ptr_r + 8'h01;
              end
              drv_nxt    = 1'b1;
              bus_st_nxt = ldr_pkg::B_RX_ACK;
            end
          end
        end
        ldr_pkg::B_ADDR_ACK, ldr_pkg::B_RX_ACK: begin
          if (scl_fall) begin
            cnt_nxt = '0;
            if (bus_st_r == ldr_pkg::B_ADDR_ACK && rw_r) begin
              tx_nxt     = rd_data;
              drv_nxt    = ~rd_data[ldr_pkg::MSB];
              ptr_nxt    = ptr_r + 8'h01;
              bus_st_nxt = ldr_pkg::B_TX;
            end else begin
              drv_nxt    = 1'b0;
              bus_st_nxt = ldr_pkg::B_RX;
            end
          end
        end
        ldr_pkg::B_TX: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (byte_in) begin
              drv_nxt    = 1'b0;
              bus_st_nxt = ldr_pkg::B_TX_ACK;
            end else begin
              tx_nxt  = {tx_r[ldr_pkg::MSB-1:0], 1'b0};
              drv_nxt = ~tx_r[ldr_pkg::MSB-1];
            end
          end
        end
        ldr_pkg::B_TX_ACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall) begin
            cnt_nxt = '0;
            if (nack_r) begin
              drv_nxt    = 1'b0;
              bus_st_nxt = ldr_pkg::B_IDLE;
            end else begin
              tx_nxt     = rd_data;
              drv_nxt    = ~rd_data[ldr_pkg::MSB];
              ptr_nxt    = ptr_r + 8'h01;
              bus_st_nxt = ldr_pkg::B_TX;
            end
          end
        end
        default: begin
          bus_st_nxt = ldr_pkg::B_IDLE;
          drv_nxt    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      bus_st_r   <= ldr_pkg::B_IDLE;
      cnt_r      <= '0;
      rx_r       <= '0;
      tx_r       <= '0;
      ptr_r      <= '0;
      ptr_seen_r <= 1'b0;
      rw_r       <= 1'b0;
      nack_r     <= 1'b0;
      drv_r      <= 1'b0;
    end else if (CE) begin
      bus_st_r   <= bus_st_nxt;
      cnt_r      <= cnt_nxt;
      rx_r       <= rx_nxt;
      tx_r       <= tx_nxt;
      ptr_r      <= ptr_nxt;
      ptr_seen_r <= ptr_seen_nxt;
      rw_r       <= rw_nxt;
      nack_r     <= nack_nxt;
      drv_r      <= drv_nxt;
    end
  end

  // Register write path: loader has priority, bus locked out meanwhile
  logic [7:0] str_r, cfg_r, flt_r, peak_r, rsv_r, opt_r;

  wire logic       ld_wr   = (ld_st_r == ldr_pkg::L_STORE);
  wire logic       host_wr = bus_wr & load_done_r & ~en_s;
  wire logic       wr_en   = ld_wr | host_wr;
  wire logic [7:0] wr_addr = ld_wr ? nvm_addr : ptr_r;
  wire logic [7:0] wr_data = ld_wr ? nvm_data : rx_r;

  // Only writable offsets decode; read-only ones have no enable
  wire logic we_str  = wr_en & (wr_addr == ldr_pkg::OFF_STR);
  wire logic we_cfg  = wr_en & (wr_addr == ldr_pkg::OFF_CFG);
  wire logic we_flt  = wr_en & (wr_addr == ldr_pkg::OFF_FLT);
  wire logic we_peak = wr_en & (wr_addr == ldr_pkg::OFF_PEAK);
  wire logic we_rsv  = wr_en & (wr_addr == ldr_pkg::OFF_RSV);
  wire logic we_opt  = wr_en & (wr_addr == ldr_pkg::OFF_OPT);
  wire logic any_we  = we_str | we_cfg | we_flt | we_peak | we_rsv | we_opt;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      str_r  <= ldr_pkg::RST_STR;
      cfg_r  <= ldr_pkg::RST_CFG;
      flt_r  <= ldr_pkg::RST_FLT;
      peak_r <= ldr_pkg::RST_PEAK;
      rsv_r  <= ldr_pkg::RST_RSV;
      opt_r  <= ldr_pkg::RST_OPT;
    end else if (CE) begin
      if (we_str)  str_r  <= wr_data;
      if (we_cfg)  cfg_r  <= wr_data;
      if (we_flt)  flt_r  <= wr_data;
      if (we_peak) peak_r <= wr_data;
      if (we_rsv)  rsv_r  <= wr_data;
      if (we_opt)  opt_r  <= wr_data;
    end
  end

  // Read selection
  wire logic [7:0] ost_byte =
    (8'(FEEDBACK_IN_IGNORE_FLAG) << ldr_pkg::OST_IGN) |
    (8'(OPTIMIZER_OUTCOME_BITS) << ldr_pkg::OST_OUT_LO);

  assign rd_data =
    (ptr_r == ldr_pkg::OFF_STR)  ? str_r  :
    (ptr_r == ldr_pkg::OFF_CFG)  ? cfg_r  :
    (ptr_r == ldr_pkg::OFF_FLT)  ? flt_r  :
    (ptr_r == ldr_pkg::OFF_PEAK) ? peak_r :
    (ptr_r == ldr_pkg::OFF_RSV)  ? rsv_r  :
    (ptr_r == ldr_pkg::OFF_OPT)  ? opt_r  :
    (ptr_r == ldr_pkg::OFF_DAC1) ? OPTIMIZER_DAC_ONE_READBACK :
    (ptr_r == ldr_pkg::OFF_DAC2) ? OPTIMIZER_DAC_TWO_READBACK :
    (ptr_r == ldr_pkg::OFF_OST)  ? ost_byte : ldr_pkg::RD_NONE;

  // Outputs
  assign SDA_OUT                = 1'b0;
  assign SDA_OE                 = drv_r;
  assign STRING_OUTPUT_SWITCHES = str_r[ldr_pkg::STR_NUM-1:0];
  assign SLEEP_ON               = cfg_r[ldr_pkg::CFG_SLEEP];
  assign OPTIMIZER_OUTPUT_ON    = cfg_r[ldr_pkg::CFG_OPT_OUT];
  assign OPEN_DETECT_ON         = cfg_r[ldr_pkg::CFG_OPEN];
  assign SHORT_DETECT_ON        = cfg_r[ldr_pkg::CFG_SHORT];
  assign BUS_TIMEOUT_ON         = cfg_r[ldr_pkg::CFG_TIMEOUT];
  assign CURRENT_FOLDBACK_ON    = cfg_r[ldr_pkg::CFG_FOLDBACK];
  assign FAULT_WATCH_SELECT     = flt_r[ldr_pkg::STR_NUM-1:0];
  assign PEAK_CURRENT_LEVEL     = peak_r;
  assign OPTIMIZER_CONTROL      = opt_r;
  assign LOAD_DONE              = load_done_r;

  // Checks
  sequence s_load_end;
    $rose(load_done_r);
  endsequence

  sequence s_peak_store;
    ld_st_r == ldr_pkg::L_STORE && CE && nvm_addr == ldr_pkg::OFF_PEAK;
  endsequence

  property p_nvm_store;
    @(posedge CLK) disable iff (!RST_B)
      s_peak_store |=> peak_r == $past(nvm_data);
  endproperty
  a_nvm_store: assert property (p_nvm_store)
    else $error("loader did not copy store data");

  property p_str_def;
    @(posedge CLK) disable iff (!RST_B)
      s_load_end |-> str_r == ldr_pkg::RST_STR && STRING_OUTPUT_SWITCHES
                     == ldr_pkg::RST_STR[ldr_pkg::STR_NUM-1:0];
  endproperty
  a_str_def: assert property (p_str_def)
    else $error("string switches not at default after load");

  property p_cfg_def;
    @(posedge CLK) disable iff (!RST_B)
      s_load_end |-> cfg_r == ldr_pkg::RST_CFG && !SLEEP_ON
                     && !CURRENT_FOLDBACK_ON && BUS_TIMEOUT_ON;
  endproperty
  a_cfg_def: assert property (p_cfg_def)
    else $error("configuration not at default after load");

  property p_flt_def;
    @(posedge CLK) disable iff (!RST_B)
      s_load_end |-> flt_r == ldr_pkg::RST_FLT;
  endproperty
  a_flt_def: assert property (p_flt_def)
    else $error("fault watch select not at default after load");

  property p_peak_def;
    @(posedge CLK) disable iff (!RST_B)
      s_load_end |-> PEAK_CURRENT_LEVEL == ldr_pkg::RST_PEAK;
  endproperty
  a_peak_def: assert property (p_peak_def)
    else $error("peak current level not at default after load");

  property p_opt_def;
    @(posedge CLK) disable iff (!RST_B)
      s_load_end |-> OPTIMIZER_CONTROL == ldr_pkg::RST_OPT;
  endproperty
  a_opt_def: assert property (p_opt_def)
    else $error("optimizer control not at default after load");

  property p_en_reload;
    @(posedge CLK) disable iff (!RST_B)
      (en_s && CE && ld_st_r == ldr_pkg::L_DONE) |=>
        ld_st_r == ldr_pkg::L_FETCH && ld_idx_r == '0 && !load_done_r;
  endproperty
  a_en_reload: assert property (p_en_reload)
    else $error("chip enable did not restart default load");

  // A dropped host write must leave every register untouched
  property p_en_lock;
    @(posedge CLK) disable iff (!RST_B)
      (bus_wr && !ld_wr && (en_s || !load_done_r)) |=>
        $stable({str_r, cfg_r, flt_r, peak_r, rsv_r, opt_r});
  endproperty
  a_en_lock: assert property (p_en_lock)
    else $error("host write accepted during default load");

  property p_ro_ignored;
    @(posedge CLK) disable iff (!RST_B)
      (bus_wr && !ld_wr && (ptr_r == ldr_pkg::OFF_DAC1
        || ptr_r == ldr_pkg::OFF_DAC2 || ptr_r == ldr_pkg::OFF_OST)) |=>
        $stable({str_r, cfg_r, flt_r, peak_r, rsv_r, opt_r});
  endproperty
  a_ro_ignored: assert property (p_ro_ignored)
    else $error("write to read-only register decoded");

endmodule : ldr_regbank

// File: verification/ldr_host.sv
`timescale 1ns/10ps
module ldr_host (
  // Clock
  input  wire logic clk,
  // Bus pins
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Data changes only while the clock is low
  task automatic bit_x(input logic b, output logic s);
    @(posedge clk) sda_low <= ~b;
    tick(6);
    @(posedge clk) scl <= 1'b1;
    tick(8);
    s = sda_in;
    @(posedge clk) scl <= 1'b0;
  endtask : bit_x

  task automatic start();
    @(posedge clk) sda_low <= 1'b0;
    tick(4);
    @(posedge clk) scl <= 1'b1;
    tick(8);
    @(posedge clk) sda_low <= 1'b1;
    tick(8);
    @(posedge clk) scl <= 1'b0;
  endtask : start

  task automatic stop();
    @(posedge clk) sda_low <= 1'b1;
    tick(6);
    @(posedge clk) scl <= 1'b1;
    tick(8);
    @(posedge clk) sda_low <= 1'b0;
    tick(8);
  endtask : stop

  task automatic tx(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(v[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask : tx

  task automatic rx(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      v[i] = s;
    end
    bit_x(last, s);
  endtask : rx

  function automatic logic listed(input logic [7:0] a);
    return a inside {ldr_pkg::OFF_STR, ldr_pkg::OFF_CFG, ldr_pkg::OFF_FLT,
                     ldr_pkg::OFF_PEAK, ldr_pkg::OFF_RSV, ldr_pkg::OFF_OPT,
                     ldr_pkg::OFF_DAC1, ldr_pkg::OFF_DAC2, ldr_pkg::OFF_OST};
  endfunction : listed

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic ack);
    logic a0;
    logic a1;
    logic a2;
    ack = 1'b1;
    if (listed(a)) begin
      if (a == ldr_pkg::OFF_RSV) d = 8'h04;
      start();
      tx({ldr_pkg::DEV_ADDR, 1'b0}, a0);
      tx(a, a1);
      tx(d, a2);
      stop();
      ack = a0 & a1 & a2;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ack);
    logic a0;
    logic a1;
    logic a2;
    start();
    tx({ldr_pkg::DEV_ADDR, 1'b0}, a0);
    tx(a, a1);
    start();
    tx({ldr_pkg::DEV_ADDR, 1'b1}, a2);
    rx(1'b1, d);
    stop();
    ack = a0 & a1 & a2;
  endtask : rd
endmodule : ldr_host

// File: verification/tb.sv
`timescale 1ns/10ps
module tb;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       en_pin = 1'b0;
  logic       ce = 1'b1;
  logic [7:0] dac1 = 8'h00;
  logic [7:0] dac2 = 8'h00;
  logic       ign = 1'b0;
  logic [1:0] outc = 2'h0;
  logic       scl, sda_low, sda_out, sda_oe, load_done;
  logic       sleep_o, optout_o, open_o, short_o, tmo_o, fold_o;
  logic [3:0] str_o, flt_o;
  logic [7:0] peak_o, optc_o;
  wire        sda_w = !(sda_low || (sda_oe && !sda_out));
  logic [7:0] mdl [0:31];
  logic [7:0] lst [0:5] = '{8'h00, 8'h02, 8'h08, 8'h0e, 8'h10, 8'h11};
  int         errors = 0;
  int         tests_run = 0;
  int         seed = 44;
  int         cyc = 0;

  always #2 clk = ~clk;

  ldr_host host_u (.clk(clk), .sda_in(sda_w), .scl(scl), .sda_low(sda_low));

  ldr_regbank dut_u (
    .CLK(clk), .RST_B(rst_b), .CE(ce), .EN_PIN(en_pin),
    .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .OPTIMIZER_DAC_ONE_READBACK(dac1), .OPTIMIZER_DAC_TWO_READBACK(dac2),
    .FEEDBACK_IN_IGNORE_FLAG(ign), .OPTIMIZER_OUTCOME_BITS(outc),
    .STRING_OUTPUT_SWITCHES(str_o), .SLEEP_ON(sleep_o),
    .OPTIMIZER_OUTPUT_ON(optout_o), .OPEN_DETECT_ON(open_o),
    .SHORT_DETECT_ON(short_o), .BUS_TIMEOUT_ON(tmo_o),
    .CURRENT_FOLDBACK_ON(fold_o), .FAULT_WATCH_SELECT(flt_o),
    .PEAK_CURRENT_LEVEL(peak_o), .OPTIMIZER_CONTROL(optc_o),
    .LOAD_DONE(load_done)
  );

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // Whole run is about 36k cycles of bus traffic
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] dflt(input logic [7:0] a);
    case (a)
      8'h00:   return 8'h0f;
      8'h02:   return 8'h4e;
      8'h08:   return 8'h0f;
      8'h0e:   return 8'h7f;
      8'h10:   return 8'h04;
      8'h11:   return 8'h1a;
      default: return 8'h00;
    endcase
  endfunction : dflt

  task automatic load_mdl();
    for (int a = 0; a < 32; a++) mdl[a] = dflt(8'(a));
  endtask : load_mdl

  task automatic wait_done();
    int n;
    n = 0;
    while (load_done !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("load_done", {7'h0, load_done}, 8'h01);
  endtask : wait_done

  task automatic chk_ports();
    chk("switches", {4'h0, str_o}, {4'h0, mdl[0][3:0]});
    chk("config", {fold_o, tmo_o, 2'b00, short_o, open_o, optout_o,
                   sleep_o}, mdl[2] & 8'hcf);
    chk("fault_sel", {4'h0, flt_o}, {4'h0, mdl[8][3:0]});
    chk("peak", peak_o, mdl[14]);
    chk("opt_ctl", optc_o, mdl[17]);
  endtask : chk_ports

  task automatic chk_regs();
    logic [7:0] d;
    logic       ack;
    for (int i = 0; i < 6; i++) begin
      host_u.rd(lst[i], d, ack);
      chk("ack", {7'h0, ack}, 8'h01);
      chk("readback", d, mdl[lst[i][4:0]]);
    end
  endtask : chk_regs

  task automatic rand_writes(input int n);
    logic [7:0] a;
    logic [7:0] d;
    logic       ack;
    for (int k = 0; k < n; k++) begin
      a = lst[$unsigned($random(seed)) % 6];
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      host_u.wr(a, d, ack);
      mdl[a[4:0]] = (a == 8'h10) ? 8'h04 : d;
      chk("write_ack", {7'h0, ack}, 8'h01);
    end
  endtask : rand_writes

  initial begin
    logic [7:0] d;
    logic       ack;
    load_mdl();
    repeat (10) @(posedge clk);
    chk_ports();
    @(posedge clk) rst_b <= 1'b1;
    wait_done();
    chk_regs();
    $display("Test power-up defaults done");

    rand_writes(12);
    chk_regs();
    chk_ports();
    $display("Test random writes done");

    // Clock enable low freezes everything, the chip enable pin included
    @(posedge clk) begin
      ce     <= 1'b0;
      en_pin <= 1'b1;
    end
    repeat (30) @(posedge clk);
    chk_ports();
    @(posedge clk) begin
      en_pin <= 1'b0;
      ce     <= 1'b1;
    end
    repeat (4) @(posedge clk);
    chk_ports();
    chk("load_held", {7'h0, load_done}, 8'h01);
    $display("Test clock enable hold done");

    // Read-only places keep the live readback values
    @(posedge clk) begin
      dac1 <= 8'($random(seed));
      dac2 <= 8'($random(seed));
      ign  <= 1'($random(seed));
      outc <= 2'($random(seed));
    end
    host_u.wr(8'h14, ~dac1, ack);
    host_u.wr(8'h15, ~dac2, ack);
    host_u.wr(8'h18, 8'hff, ack);
    chk("ro_ack", {7'h0, ack}, 8'h01);
    host_u.rd(8'h14, d, ack);
    chk("dac_one", d, dac1);
    host_u.rd(8'h15, d, ack);
    chk("dac_two", d, dac2);
    host_u.rd(8'h18, d, ack);
    chk("opt_state", d, {2'b00, ign, outc, 3'b000});
    host_u.rd(8'h01, d, ack);
    chk("unmapped", d, 8'h00);
    chk_regs();
    $display("Test read-only places done");

    rand_writes(4);
    @(posedge clk) en_pin <= 1'b1;
    repeat (30) @(posedge clk);
    load_mdl();
    chk_ports();
    host_u.wr(8'h00, 8'h05, ack);
    @(posedge clk) en_pin <= 1'b0;
    repeat (4) @(posedge clk);
    wait_done();
    chk_ports();
    chk_regs();
    $display("Test chip enable done");

    rand_writes(4);
    @(posedge clk) rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    load_mdl();
    chk_ports();
    @(posedge clk) rst_b <= 1'b1;
    wait_done();
    chk_regs();
    $display("Test second reset done");
    end_sim();
  end
endmodule : tb
